/* File: hdl/flash_status_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - identifier space: 64-bit factory segment plus a user-programmable segment
// - factory segment refuses user programming; neither segment can be erased
// - after identifier lockout no user-segment writes (factory-mode factory writes still land); lock status bit stays set
// - hold pause only in single-lane mode; off in mux mode or pin-config 1
// - with select low, hold falling enters pause at a clock-low phase
// - hold rising leaves pause at a clock-low phase; transfer continues unchanged
// - while paused the serial output floats; data input and clock are ignored
// - select high while paused resets interface logic; pause lasts while hold low
// - status bits 0 and 7 read 1 while erase or program runs
// - status may be read during erase or program to poll completion
// - status bit 1 shows write-enable latch; clear latch refuses write commands
// - latch cleared by reset, disable, completions, protect writes, suspend, status write
// - status bit 2 set on suspend during erase, cleared on resume
// - status bit 3 set on suspend during program, cleared on resume
// - status bit 4 set by protection lock-down, cleared only by power cycle
// - status bit 5 powers up 1 if identifier lockout ever succeeded
// - status bit 6 is reserved and reads 0
// - config bit 1 pin-config, read-write, powers up 0, disables protect and hold
// - config bit 3 reads 1 until any permanent block lock bit is set
// - config register read-write; bits 0, 2, 4, 5 read 0
// - config bit 7 nonvolatile protect-pin enable, kept across power cycles
// - powers up single-lane; a command switches to four-bit mux mode
package flash_status_pkg;

	localparam int SID_BYTES = 2048;
	localparam int SID_ADDR_W = 11;
	localparam logic [10:0] FACTORY_BYTES = 11'h008;
	localparam int PERM_LOCK_BITS = 40;

	localparam int ST_BUSY_LO = 0;
	localparam int ST_WEL = 1;
	localparam int ST_ERASE_SUSP = 2;
	localparam int ST_PROG_SUSP = 3;
	localparam int ST_LOCKDOWN = 4;
	localparam int ST_SID_LOCK = 5;
	localparam int ST_BUSY_HI = 7;
	localparam int CF_PIN_CONFIG = 1;
	localparam int CF_NO_PERM_LOCK = 3;
	localparam int CF_PROTECT_PIN = 7;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h08;

	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_READ_CONFIG = 8'h35;
	localparam logic [7:0] OP_ENABLE_QUAD = 8'h38;
	localparam logic [7:0] OP_RESET_QUAD = 8'hff;
	localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_SUSPEND = 8'hb0;
	localparam logic [7:0] OP_RESUME = 8'h30;
	localparam logic [7:0] OP_PROTECT_WRITE = 8'h42;
	localparam logic [7:0] OP_PROTECT_LOCKDOWN = 8'h8d;

	localparam logic [2:0] LAST_BIT_SINGLE = 3'h7;
	localparam logic [2:0] LAST_BIT_QUAD = 3'h1;

	typedef enum logic [2:0] {ENG_IDLE, ENG_PROGRAM, ENG_ERASE, ENG_ID_PROGRAM,
		ENG_ID_LOCKOUT} engine_op_type;

	typedef enum logic [2:0] {LS_OPCODE, LS_DUMMY, LS_READ, LS_WDATA,
		LS_IGNORE} link_state_type;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] data;
	} link_cmd_type;

	typedef struct packed {
		logic valid;
		logic allowed;
		logic [7:0] opcode;
	} cmd_out_type;

	typedef struct packed {
		logic valid;
		logic [10:0] addr;
		logic [7:0] data;
	} sid_write_type;

	// commands that run without the write-enable latch
	function automatic logic free_of_latch(input logic [7:0] op);
		return op == OP_WRITE_ENABLE || op == OP_WRITE_DISABLE || op == OP_READ_STATUS ||
			op == OP_READ_CONFIG || op == OP_ENABLE_QUAD || op == OP_RESET_QUAD ||
			op == OP_RESET_ENABLE || op == OP_RESET || op == OP_SUSPEND || op == OP_RESUME;
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic [3:0] sio,
		input logic quad);
		return quad ? {sr[3:0], sio} : {sr[6:0], sio[0]};
	endfunction

endpackage

/* File: hdl/sid_memory.sv */
`timescale 1ns/100ps
module sid_memory
	import flash_status_pkg::*;
(
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [10:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [10:0] rd_addr,
	output logic [7:0] rd_data
);

	logic [7:0] mem [0:SID_BYTES-1];

	// write-only store: no erase path exists
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule

/* File: hdl/flash_status_hold.sv */
`timescale 1ns/100ps
module flash_status_hold
	import flash_status_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] sio_in,
	output logic [3:0] sio_out,
	output logic [3:0] sio_oe,
	output logic hold_paused,
	input wire logic engine_busy,
	input wire engine_op_type engine_op,
	input wire logic engine_done,
	input wire logic [PERM_LOCK_BITS-1:0] permanent_lock_bits,
	input wire logic sid_lock_nv,
	input wire logic protect_pin_enable_nv,
	input wire logic factory_mode,
	input wire sid_write_type sid_write,
	input wire logic [10:0] sid_rd_addr,
	output logic [7:0] sid_rd_data,
	output cmd_out_type cmd_out,
	output logic [7:0] device_status,
	output logic [7:0] device_configuration,
	output logic four_bit_mux_mode,
	output logic protect_pin_enable
);

	//////////////////////////////////////////////////////////////////////////
	// reference-domain state

	logic link_clear;
	logic nv_loaded;
	logic write_enable_latch;
	logic erase_suspended_flag;
	logic program_suspended_flag;
	logic protect_lockdown_flag;
	logic sid_locked;
	logic pin_config_bit;
	logic reset_armed;
	logic wp_s1, wp_s2;
	logic tog_s1, tog_s2, tog_s3;

	//////////////////////////////////////////////////////////////////////////
	// link-domain state

	link_state_type state;
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] opcode;
	logic byte_cnt;
	link_cmd_type cmd_word;
	logic cmd_toggle;
	logic pause_latch;
	logic [3:0] out_bits;
	logic quad_s1, quad_s2, pincfg_s1, pincfg_s2;
	logic [7:0] status_s1, status_s2, config_s1, config_s2;

	//////////////////////////////////////////////////////////////////////////
	// link-side decode

	wire link_rst = cs_n | link_clear;
	wire hold_n = sio_in[3];
	wire hold_en = ~quad_s2 & ~pincfg_s2;
	wire pause_d = hold_en & ~hold_n;
	// low phase follows the pin, high phase holds what the low phase ended with
	wire paused = hold_en & ((sck & ~cs_n) ? pause_latch : ~hold_n);
	wire [2:0] last_bit = quad_s2 ? LAST_BIT_QUAD : LAST_BIT_SINGLE;
	wire byte_end = (bit_cnt == last_bit);
	wire [7:0] next_shreg = shift_in(shreg, sio_in, quad_s2);
	wire op_is_read = (next_shreg == OP_READ_STATUS) || (next_shreg == OP_READ_CONFIG);
	wire op_is_wstat = (next_shreg == OP_WRITE_STATUS);
	wire emit_opcode = (state == LS_OPCODE) & ~op_is_read & ~op_is_wstat;
	wire emit_wdata = (state == LS_WDATA) & byte_cnt;
	wire emit = ~pause_d & byte_end & (emit_opcode | emit_wdata);
	wire [7:0] read_byte = (opcode == OP_READ_CONFIG) ? config_s2 : status_s2;
	wire [3:0] lane_mask = quad_s2 ? 4'hf : 4'h2;

	assign sio_out = out_bits;
	assign sio_oe = (~cs_n & (state == LS_READ) & ~paused) ? lane_mask : 4'h0;
	assign hold_paused = paused;

	//////////////////////////////////////////////////////////////////////////
	// link domain: reference state crosses as independent level bits

	always_ff @(posedge sck or posedge link_clear) begin
		if (link_clear) begin
			quad_s1 <= 1'b0;
			quad_s2 <= 1'b0;
			pincfg_s1 <= 1'b0;
			pincfg_s2 <= 1'b0;
			status_s1 <= STATUS_RESET;
			status_s2 <= STATUS_RESET;
			config_s1 <= CONFIG_RESET;
			config_s2 <= CONFIG_RESET;
		end else begin
			quad_s1 <= four_bit_mux_mode;
			quad_s2 <= quad_s1;
			pincfg_s1 <= pin_config_bit;
			pincfg_s2 <= pincfg_s1;
			status_s1 <= device_status;
			status_s2 <= status_s1;
			config_s1 <= device_configuration;
			config_s2 <= config_s1;
		end
	end

	// survives select going high so the reference side reads a stable word
	always_ff @(posedge sck or posedge link_clear) begin
		if (link_clear) begin
			cmd_word <= '0;
			cmd_toggle <= 1'b0;
			pause_latch <= 1'b0;
		end else begin
			pause_latch <= pause_d;
			if (emit) begin
				cmd_word <= {emit_wdata ? opcode : next_shreg, emit_wdata ? next_shreg : 8'h00};
				cmd_toggle <= ~cmd_toggle;
			end
		end
	end

	always_ff @(posedge sck or posedge link_rst) begin
		if (link_rst) begin
			state <= LS_OPCODE;
			bit_cnt <= 3'h0;
			shreg <= 8'h00;
			opcode <= 8'h00;
			byte_cnt <= 1'b0;
		end else if (!pause_d) begin
			bit_cnt <= byte_end ? 3'h0 : bit_cnt + 3'h1;
			shreg <= next_shreg;
			if (byte_end) begin
				unique case (state)
					LS_OPCODE: begin
						opcode <= next_shreg;
						if (op_is_read) begin
							state <= quad_s2 ? LS_DUMMY : LS_READ;
						end else if (op_is_wstat) begin
							state <= LS_WDATA;
						end else begin
							state <= LS_IGNORE;
						end
					end
					LS_DUMMY: begin
						state <= LS_READ;
					end
					LS_WDATA: begin
						byte_cnt <= 1'b1;
						if (byte_cnt) begin
							state <= LS_IGNORE;
						end
					end
					LS_READ, LS_IGNORE: begin
						state <= state;
					end
				endcase
			end
		end
	end

	// output changes after the falling edge, frozen through a pause
	always_ff @(negedge sck or posedge link_rst) begin
		if (link_rst) begin
			out_bits <= 4'h0;
		end else if (!pause_latch && state == LS_READ) begin
			if (quad_s2) begin
				out_bits <= bit_cnt[0] ? read_byte[3:0] : read_byte[7:4];
			end else begin
				out_bits <= {2'b00, read_byte[3'h7 - bit_cnt], 1'b0};
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// reference domain: command event from the link

	wire cmd_event = tog_s2 ^ tog_s3;
	wire [7:0] op = cmd_word.opcode;
	wire [7:0] wdata = cmd_word.data;
	wire ev_wren = cmd_event & (op == OP_WRITE_ENABLE);
	wire ev_write_disable_cmd = cmd_event & (op == OP_WRITE_DISABLE);
	wire ev_suspend = cmd_event & (op == OP_SUSPEND);
	wire ev_resume = cmd_event & (op == OP_RESUME);
	wire ev_wstat = cmd_event & (op == OP_WRITE_STATUS);
	wire ev_protect = cmd_event & (op == OP_PROTECT_WRITE) & write_enable_latch;
	wire ev_lockdown = cmd_event & (op == OP_PROTECT_LOCKDOWN) & write_enable_latch;
	wire reset_go = cmd_event & (op == OP_RESET) & reset_armed;
	wire config_protected = ~wp_s2 & ~pin_config_bit & protect_pin_enable;
	wire config_write = ev_wstat & write_enable_latch & ~config_protected;
	wire clear_wel = reset_go | ev_write_disable_cmd | engine_done | ev_protect | ev_lockdown |
		ev_suspend | ev_wstat;
	wire sid_locked_done = engine_done & (engine_op == ENG_ID_LOCKOUT);
	wire sid_user_ok = ~sid_locked & (sid_write.addr >= FACTORY_BYTES);
	wire sid_factory_ok = factory_mode & (sid_write.addr < FACTORY_BYTES);
	wire sid_wr_en = sid_write.valid & (sid_user_ok | sid_factory_ok);
	wire [7:0] next_status = {engine_busy, 1'b0, sid_locked, protect_lockdown_flag,
		program_suspended_flag, erase_suspended_flag, write_enable_latch,
		engine_busy};
	wire [7:0] next_config = {protect_pin_enable, 3'b000, ~|permanent_lock_bits, 1'b0,
		pin_config_bit, 1'b0};

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			link_clear <= 1'b1;
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			wp_s1 <= 1'b1;
			wp_s2 <= 1'b1;
		end else begin
			link_clear <= 1'b0;
			tog_s1 <= cmd_toggle;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			wp_s1 <= sio_in[2];
			wp_s2 <= wp_s1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// status and configuration bits; set wins over a clear in the same cycle

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			write_enable_latch <= 1'b0;
			erase_suspended_flag <= 1'b0;
			program_suspended_flag <= 1'b0;
			reset_armed <= 1'b0;
			four_bit_mux_mode <= 1'b0;
		end else begin
			if (ev_wren) begin
				write_enable_latch <= 1'b1;
			end else if (clear_wel) begin
				write_enable_latch <= 1'b0;
			end
			if (ev_suspend && engine_busy && engine_op == ENG_ERASE) begin
				erase_suspended_flag <= 1'b1;
			end else if (ev_resume || reset_go) begin
				erase_suspended_flag <= 1'b0;
			end
			if (ev_suspend && engine_busy && engine_op == ENG_PROGRAM) begin
				program_suspended_flag <= 1'b1;
			end else if (ev_resume || reset_go) begin
				program_suspended_flag <= 1'b0;
			end
			if (cmd_event) begin
				reset_armed <= (op == OP_RESET_ENABLE);
			end
			if (cmd_event && op == OP_ENABLE_QUAD) begin
				four_bit_mux_mode <= 1'b1;
			end else if ((cmd_event && op == OP_RESET_QUAD) || reset_go) begin
				four_bit_mux_mode <= 1'b0;
			end
		end
	end

	// power-only state: the reset command leaves it alone
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			nv_loaded <= 1'b0;
			protect_lockdown_flag <= 1'b0;
			sid_locked <= 1'b0;
			pin_config_bit <= 1'b0;
			protect_pin_enable <= 1'b0;
		end else begin
			nv_loaded <= 1'b1;
			if (ev_lockdown) begin
				protect_lockdown_flag <= 1'b1;
			end
			// nonvolatile levels caught once after reset release
			if (!nv_loaded) begin
				sid_locked <= sid_lock_nv | sid_locked_done;
				protect_pin_enable <= protect_pin_enable_nv;
			end else begin
				if (sid_locked_done) begin
					sid_locked <= 1'b1;
				end
				if (config_write) begin
					protect_pin_enable <= wdata[CF_PROTECT_PIN];
				end
			end
			if (config_write) begin
				pin_config_bit <= wdata[CF_PIN_CONFIG];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cmd_out <= '0;
			device_status <= STATUS_RESET;
			device_configuration <= CONFIG_RESET;
		end else begin
			cmd_out.valid <= cmd_event;
			cmd_out.opcode <= op;
			cmd_out.allowed <= write_enable_latch | free_of_latch(op);
			device_status <= next_status;
			device_configuration <= next_config;
		end
	end

	sid_memory sid_store (
		.clk(ref_clk),
		.wr_en(sid_wr_en),
		.wr_addr(sid_write.addr),
		.wr_data(sid_write.data),
		.rd_addr(sid_rd_addr),
		.rd_data(sid_rd_data)
	);

endmodule

/* File: tb/flash_status_monitor.sv */
`timescale 1ns/100ps
module flash_status_monitor
	import flash_status_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [3:0] sio_oe,
	input wire logic hold_paused,
	input wire logic engine_busy,
	input wire engine_op_type engine_op,
	input wire logic [PERM_LOCK_BITS-1:0] permanent_lock_bits,
	input wire cmd_out_type cmd_out,
	input wire logic [7:0] device_status,
	input wire logic [7:0] device_configuration,
	input wire logic four_bit_mux_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	chk_busy_follow: assert property (
		$changed(engine_busy) |-> ##[1:3] (device_status[ST_BUSY_LO] == engine_busy
		&& device_status[ST_BUSY_HI] == engine_busy)) else $error("busy bits lag");
	chk_reserved_zero: assert property (
		!device_status[6] && (device_configuration & 8'h35) == 8'h00)
		else $error("reserved bit set");
	chk_perm_lock: assert property (
		|permanent_lock_bits |-> ##[1:4] !device_configuration[CF_NO_PERM_LOCK])
		else $error("permanent lock not shown");
	chk_sid_sticky: assert property (
		device_status[ST_SID_LOCK] |=> device_status[ST_SID_LOCK])
		else $error("identifier lock dropped");
	chk_lockdown_sticky: assert property (
		device_status[ST_LOCKDOWN] |=> device_status[ST_LOCKDOWN])
		else $error("lockdown dropped");
	chk_paused_float: assert property (
		hold_paused |-> sio_oe == 4'h0) else $error("output driven while paused");
	chk_wel_clear: assert property (
		cmd_out.valid && cmd_out.opcode == OP_WRITE_DISABLE |-> ##[0:3] !device_status[ST_WEL])
		else $error("latch not cleared");
	chk_wel_refuse: assert property (
		cmd_out.valid && cmd_out.opcode == OP_PROTECT_LOCKDOWN && !cmd_out.allowed
		&& !device_status[ST_LOCKDOWN] |=> (!device_status[ST_LOCKDOWN]) [*3])
		else $error("lockdown without latch");
	chk_erase_susp: assert property (
		cmd_out.valid && cmd_out.opcode == OP_SUSPEND && engine_busy && engine_op == ENG_ERASE
		|-> ##[0:3] device_status[ST_ERASE_SUSP]) else $error("erase suspend not flagged");
	chk_mux_no_pause: assert property (
		four_bit_mux_mode && $past(four_bit_mux_mode, 8) |-> !$rose(hold_paused))
		else $error("pause in mux mode");
	cov_pause: cover property (hold_paused);
	cov_sid_lock: cover property ($rose(device_status[ST_SID_LOCK]));
	cov_refused: cover property (cmd_out.valid && !cmd_out.allowed);
endmodule
bind flash_status_hold flash_status_monitor i_mon (.*);

/* File: tb/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic [3:0] sio_out,
	input wire logic [3:0] sio_oe,
	output logic sck,
	output logic cs_n,
	output logic [3:0] sio_in
);
	localparam realtime HALF = 7.5;
	logic din = 1'b0;
	// spare lane carries the inverse so a stale level never reads as data
	assign sio_in = {hold_n, wp_n, ~din, din};
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
	end
	//////////////////////////////////////////////////////////////////////////
	// mode 0: clock stands still between frames
	task automatic open_f;
		cs_n = 1'b0;
		#(HALF);
	endtask
	task automatic close_f;
		#(HALF);
		cs_n = 1'b1;
		din = ~din;
	endtask
	// read lane taken at the rising edge; unknown when not driven
	task automatic bit_io(input logic d, output logic q);
		din = d;
		#(HALF);
		sck = 1'b1;
		q = sio_oe[1] ? sio_out[1] : 1'bx;
		#(HALF);
		sck = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
	endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top
	import flash_status_pkg::*;
;
	logic ref_clk, rst_n, sck, cs_n, hold_n, wp_n, hold_paused, factory_mode;
	logic engine_busy, engine_done, sid_lock_nv, protect_pin_enable_nv;
	logic four_bit_mux_mode, protect_pin_enable;
	logic [3:0] sio_in, sio_out, sio_oe;
	logic [PERM_LOCK_BITS-1:0] permanent_lock_bits;
	logic [10:0] sid_rd_addr;
	logic [7:0] sid_rd_data, device_status, device_configuration, rx;
	engine_op_type engine_op;
	sid_write_type sid_write;
	cmd_out_type cmd_out;
	int failures = 0;
	int n_tests = 0;
	flash_status_hold i_dut (.*);
	spi_host_model i_host (.*);
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("Checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic do_reset;
		rst_n = 1'b0;
		tick(16);
		rst_n = 1'b1;
		tick(6);
	endtask
	// one command per frame, then the spacing the decoder needs
	task automatic cmd(input logic [7:0] op, input int nd, input logic [7:0] d);
		i_host.open_f;
		i_host.byte_io(op, rx);
		repeat (nd) i_host.byte_io(d, rx);
		i_host.close_f;
		tick(10);
	endtask
	// two link clocks first: mode and pin-config bits reach the link side only on sck edges
	task automatic hold_ignored;
		logic q;
		i_host.open_f;
		repeat (2) i_host.bit_io(1'b0, q);
		tick(1);
		hold_n = 1'b0;
		tick(2);
		chk("hold ignored", 8'h00, {7'h00, hold_paused});
		hold_n = 1'b1;
		i_host.close_f;
		tick(10);
	endtask
	task automatic sid_wr(input logic [10:0] a, input logic [7:0] d);
		sid_write = '{1'b1, a, d};
		tick(1);
		sid_write.valid = 1'b0;
		tick(1);
	endtask
	task automatic sid_chk(input logic [10:0] a, input logic [7:0] d);
		sid_rd_addr = a;
		tick(2);
		chk("sid byte", d, sid_rd_data);
	endtask
	//////////////////////////////////////////////////////////////////////////
	task automatic t_power_up;
		chk("status", 8'h00, device_status);
		chk("mux mode", 8'h00, {7'h00, four_bit_mux_mode});
		cmd(OP_READ_CONFIG, 1, 8'h00);
		chk("config", 8'h08, rx);
	endtask
	task automatic t_latch;
		cmd(OP_WRITE_ENABLE, 0, 8'h00);
		cmd(OP_READ_STATUS, 1, 8'h00);
		chk("latch set", 8'h02, rx);
		cmd(OP_WRITE_DISABLE, 0, 8'h00);
		chk("latch clear", 8'h00, device_status);
	endtask
	task automatic t_suspend;
		for (int i = 0; i < 2; i++) begin
			engine_op = i ? ENG_PROGRAM : ENG_ERASE;
			engine_busy = 1'b1;
			tick(4);
			cmd(OP_READ_STATUS, 1, 8'h00);
			chk("busy poll", 8'h81, rx);
			cmd(OP_WRITE_ENABLE, 0, 8'h00);
			cmd(OP_SUSPEND, 0, 8'h00);
			engine_busy = 1'b0;
			tick(4);
			chk("suspended", i ? 8'h08 : 8'h04, device_status);
			cmd(OP_RESUME, 0, 8'h00);
			chk("resumed", 8'h00, device_status);
		end
	endtask
	// pause in mid-opcode: clocks and data during it must not count
	task automatic t_hold;
		logic q;
		engine_busy = 1'b1;
		tick(4);
		i_host.open_f;
		for (int i = 7; i >= 4; i--) i_host.bit_io(OP_READ_STATUS[i], q);
		tick(1);
		hold_n = 1'b0;
		tick(2);
		chk("paused", 8'h01, {7'h00, hold_paused});
		repeat (4) i_host.bit_io(1'b1, q);
		tick(1);
		hold_n = 1'b1;
		tick(2);
		chk("unpaused", 8'h00, {7'h00, hold_paused});
		for (int i = 3; i >= 0; i--) i_host.bit_io(OP_READ_STATUS[i], q);
		i_host.byte_io(8'h00, rx);
		chk("status after pause", 8'h81, rx);
		tick(1);
		hold_n = 1'b0;
		tick(2);
		chk("paused lanes", 8'h00, {4'h0, sio_oe});
		i_host.close_f;
		tick(2);
		chk("paused after select", 8'h01, {7'h00, hold_paused});
		hold_n = 1'b1;
		tick(2);
		cmd(OP_READ_STATUS, 1, 8'h00);
		chk("fresh frame", 8'h81, rx);
		engine_busy = 1'b0;
		tick(4);
	endtask
	task automatic t_lockdown;
		cmd(OP_PROTECT_LOCKDOWN, 0, 8'h00);
		chk("lockdown refused", 8'h00, device_status);
		cmd(OP_WRITE_ENABLE, 0, 8'h00);
		cmd(OP_PROTECT_LOCKDOWN, 0, 8'h00);
		chk("lockdown", 8'h10, device_status);
	endtask
	task automatic t_config;
		cmd(OP_WRITE_STATUS, 2, 8'hff);
		chk("config no latch", 8'h08, device_configuration);
		cmd(OP_WRITE_ENABLE, 0, 8'h00);
		cmd(OP_WRITE_STATUS, 2, 8'hff);
		cmd(OP_READ_CONFIG, 1, 8'h00);
		chk("config", 8'h8a, rx);
		chk("latch after write", 8'h10, device_status);
		chk("protect pin", 8'h01, {7'h00, protect_pin_enable});
		hold_ignored;
		permanent_lock_bits[PERM_LOCK_BITS-1] = 1'b1;
		tick(4);
		chk("perm lock", 8'h82, device_configuration);
	endtask
	task automatic t_sid;
		factory_mode = 1'b1;
		sid_wr(11'h007, 8'h3c);
		factory_mode = 1'b0;
		sid_wr(11'h007, 8'hc3);
		sid_chk(11'h007, 8'h3c);
		sid_wr(11'h008, 8'h5a);
		sid_chk(11'h008, 8'h5a);
		engine_op = ENG_ID_LOCKOUT;
		engine_done = 1'b1;
		tick(1);
		engine_done = 1'b0;
		tick(4);
		chk("sid locked", 8'h30, device_status);
		sid_wr(11'h008, 8'ha5);
		sid_chk(11'h008, 8'h5a);
	endtask
	task automatic t_repower;
		sid_lock_nv = 1'b1;
		protect_pin_enable_nv = 1'b1;
		do_reset;
		chk("repower status", 8'h20, device_status);
		chk("repower config", 8'h80, device_configuration);
		cmd(OP_ENABLE_QUAD, 0, 8'h00);
		chk("mux mode", 8'h01, {7'h00, four_bit_mux_mode});
		hold_ignored;
	endtask
	//////////////////////////////////////////////////////////////////////////
	// whole run is under twenty microseconds
	initial begin
		#300us;
		failures++;
		end_sim;
	end
	initial begin
		{rst_n, engine_busy, engine_done, sid_lock_nv, protect_pin_enable_nv} = 5'h00;
		{hold_n, wp_n, factory_mode} = 3'h6;
		engine_op = ENG_IDLE;
		permanent_lock_bits = '0;
		sid_write = '0;
		sid_rd_addr = 11'h000;
		do_reset;
		t_power_up;
		t_latch;
		t_suspend;
		t_hold;
		t_lockdown;
		t_config;
		t_sid;
		t_repower;
		end_sim;
	end
endmodule
